/* File: logic/fta_consts.vh */
`ifndef FTA_CONSTS_VH
`define FTA_CONSTS_VH

// ==================================================
// Special function register selects
`define FTA_SFR_AW 3
`define FTA_SFR_LATCH 3'h0
`define FTA_SFR_PTRL 3'h1
`define FTA_SFR_PTRH 3'h2
`define FTA_SFR_PTRU 3'h3
`define FTA_SFR_CTL1 3'h4
`define FTA_SFR_GUARD 3'h5
`define FTA_SFR_IRQF 3'h6

// ==================================================
// Control register one field positions
`define FTA_CTL_PGD 7
`define FTA_CTL_CFG 6
`define FTA_CTL_FREE 4
`define FTA_CTL_ERR 3
`define FTA_CTL_WEN 2
`define FTA_CTL_WR 1
`define FTA_CTL_RESET 8'h00

// ==================================================
// Unlock sequence
`define FTA_KEY_FIRST 8'h55
`define FTA_KEY_SECOND 8'haa

// ==================================================
// Pointer and block geometry
`define FTA_PTR_W 22
`define FTA_PTR_SPACE_BIT 21
`define FTA_WBLK_BITS 5
`define FTA_WBLK_BYTES 32
`define FTA_EBLK_BITS 6
`define FTA_HOLD_RESET 8'hff

// ==================================================
// Table pointer update modes
`define FTA_MODE_KEEP 2'h0
`define FTA_MODE_POSTINC 2'h1
`define FTA_MODE_POSTDEC 2'h2
`define FTA_MODE_PREINC 2'h3

// ==================================================
// Timing
// 2 ms at 10 MHz
`define FTA_LONG_WRITE_CYC 15'h4e20
`define FTA_TMR_W 15

`endif

/* File: logic/fta_hold_bank.v */
`timescale 1ns/100ps
`default_nettype none
`include "fta_consts.vh"

module fta_hold_bank (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_wr,
    input wire [`FTA_WBLK_BITS-1:0] i_idx,
    input wire [7:0] i_data,
    input wire i_clear,
    input wire [`FTA_WBLK_BITS-1:0] i_rd_idx,
    output reg [7:0] o_rd_data
);

    reg [7:0] hold [0:`FTA_WBLK_BYTES-1];

    genvar g;
    generate
        for (g = 0; g < `FTA_WBLK_BYTES; g = g + 1) begin : g_byte
            always @(posedge i_mclk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    hold[g] <= `FTA_HOLD_RESET;
                end else if (i_clear) begin
                    // Erased value leaves untouched flash bytes alone
                    hold[g] <= `FTA_HOLD_RESET;
                end else if (i_wr && (i_idx == g)) begin
                    hold[g] <= i_data;
                end
            end
        end
    endgenerate

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= `FTA_HOLD_RESET;
        end else begin
            o_rd_data <= hold[i_rd_idx];
        end
    end

endmodule
`default_nettype wire

/* File: logic/fta_prog_timer.v */
`timescale 1ns/100ps
`default_nettype none
`include "fta_consts.vh"

module fta_prog_timer #(
    parameter [`FTA_TMR_W-1:0] P_CYCLES = `FTA_LONG_WRITE_CYC
) (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_start,
    input wire i_abort,
    output reg o_busy,
    output reg o_done
);

    localparam [`FTA_TMR_W-1:0] ONE = {{(`FTA_TMR_W-1){1'b0}}, 1'b1};
    reg [`FTA_TMR_W-1:0] count;

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= {`FTA_TMR_W{1'b0}};
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_abort) begin
                o_busy <= 1'b0;
                count <= {`FTA_TMR_W{1'b0}};
            end else if (i_start && !o_busy) begin
                o_busy <= 1'b1;
                count <= P_CYCLES - ONE;
                o_done <= (P_CYCLES == ONE);
            end else if (o_busy) begin
                if (count == {`FTA_TMR_W{1'b0}}) begin
                    o_busy <= 1'b0;
                end else begin
                    // Marks the last busy cycle, so all ends together
                    o_done <= (count == ONE);
                    count <= count - ONE;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: logic/fta_table_access.v */
// Overview of operation
// - Eight-bit table latch reachable as register
// - Three pointer bytes form one 22-bit address
// - Low 21 pointer bits address program memory
// - Top pointer bit selects configuration space
// - Auto updates touch only low 21 bits
// - Four pointer actions: keep, post-inc, post-dec, pre-inc
// - Table read loads addressed byte into latch
// - Table write fills holding register, not flash
// - Only low pointer bits pick holding register
// - Program write uses upper pointer bits only
// - Erase targets block from pointer bits 21:6
// - One byte read per table read
// - Address bit zero picks word high/low byte
// - Erase unit is 64 bytes, no word erase
// - No bulk erase from self-started sequence
// - Core stalls until internal timer ends cycle
// - Erase cycle lasts about 2 ms
// - Start bit only set by software, hardware clears
// - Done flag set at end, sticky until cleared
// - Error flag on abort; program and config select bits kept
`timescale 1ns/100ps
`default_nettype none
`include "fta_consts.vh"

module fta_table_access #(
    parameter [`FTA_TMR_W-1:0] P_LONG_WRITE_CYC = `FTA_LONG_WRITE_CYC
) (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_soft_rst,
    input wire i_sfr_wr,
    input wire [`FTA_SFR_AW-1:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    output reg [7:0] o_sfr_rdata,
    input wire i_tbl_op,
    input wire i_tbl_is_write,
    input wire [1:0] i_tbl_mode,
    output wire [`FTA_PTR_W-1:0] o_fl_rd_addr,
    input wire [7:0] i_fl_rd_data,
    output reg o_fl_erase,
    output reg o_fl_prog,
    output reg [`FTA_PTR_W-1:0] o_fl_op_addr,
    input wire [`FTA_WBLK_BITS-1:0] i_fl_hold_idx,
    output wire [7:0] o_fl_hold_data,
    output wire o_cpu_stall,
    output reg o_memory_done_irq_flag
);

    // ==================================================
    // Decode helper
    function sfr_hit;
        input [`FTA_SFR_AW-1:0] addr;
        input [`FTA_SFR_AW-1:0] sel;
        begin
            sfr_hit = (addr == sel);
        end
    endfunction

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_KEY1 = 2'h1;
    localparam [1:0] ST_KEY2 = 2'h2;

    // ==================================================
    // State
    reg [7:0] table_data_latch;
    reg [`FTA_PTR_W-1:0] table_byte_pointer;
    reg program_memory_select;
    reg config_space_select;
    reg erase_select;
    reg write_error_flag;
    reg write_enable_bit;
    reg write_start;
    reg [1:0] unlock_state;
    reg [1:0] next_unlock_state;
    reg erase_op;

    wire timer_busy;
    wire timer_done;
    wire sfr_wr_ctl;
    wire sfr_wr_guard;
    wire start_req;
    wire start_ok;
    wire start_bad;
    wire abort_op;

    // ==================================================
    // Pointer arithmetic
    wire [20:0] ptr_low = table_byte_pointer[20:0];
    wire [20:0] ptr_inc = ptr_low + 21'h000001;
    wire [20:0] ptr_dec = ptr_low - 21'h000001;
    wire ptr_space = table_byte_pointer[`FTA_PTR_SPACE_BIT];

    // Pre-increment reads the already advanced byte
    wire [20:0] access_low = (i_tbl_mode == `FTA_MODE_PREINC) ? ptr_inc : ptr_low;
    wire [`FTA_PTR_W-1:0] access_addr = {ptr_space, access_low};

    // Full pointer, bit 0 picks word byte, top bit picks id/config space
    assign o_fl_rd_addr = access_addr;

    wire tbl_rd = i_tbl_op && !i_tbl_is_write && !timer_busy;
    wire tbl_wr = i_tbl_op && i_tbl_is_write && !timer_busy;

    reg [20:0] next_ptr_low;

    always @* begin
        case (i_tbl_mode)
            `FTA_MODE_KEEP: begin
                next_ptr_low = ptr_low;
            end
            `FTA_MODE_POSTINC: begin
                next_ptr_low = ptr_inc;
            end
            `FTA_MODE_POSTDEC: begin
                next_ptr_low = ptr_dec;
            end
            `FTA_MODE_PREINC: begin
                next_ptr_low = ptr_inc;
            end
            default: begin
                next_ptr_low = ptr_low;
            end
        endcase
    end

    // ==================================================
    // Register writes
    assign sfr_wr_ctl = i_sfr_wr && sfr_hit(i_sfr_addr, `FTA_SFR_CTL1);
    assign sfr_wr_guard = i_sfr_wr && sfr_hit(i_sfr_addr, `FTA_SFR_GUARD);
    assign start_req = sfr_wr_ctl && i_sfr_wdata[`FTA_CTL_WR] && !write_start;

    // Program memory only; the guard pair must be the last two writes
    assign start_ok = start_req && write_enable_bit && i_sfr_wdata[`FTA_CTL_WEN]
        && (unlock_state == ST_KEY2) && i_sfr_wdata[`FTA_CTL_PGD]
        && !i_sfr_wdata[`FTA_CTL_CFG];
    assign start_bad = start_req && !start_ok;
    assign abort_op = i_soft_rst && timer_busy;

    // Any other register write breaks the unlock pair
    always @* begin
        next_unlock_state = unlock_state;
        if (i_sfr_wr) begin
            if (sfr_wr_guard && i_sfr_wdata == `FTA_KEY_FIRST) begin
                next_unlock_state = ST_KEY1;
            end else if (sfr_wr_guard && i_sfr_wdata == `FTA_KEY_SECOND && unlock_state == ST_KEY1) begin
                next_unlock_state = ST_KEY2;
            end else begin
                next_unlock_state = ST_IDLE;
            end
        end
        if (i_soft_rst) begin
            next_unlock_state = ST_IDLE;
        end
    end

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            unlock_state <= ST_IDLE;
        end else begin
            case (next_unlock_state)
                ST_IDLE: begin
                    unlock_state <= ST_IDLE;
                end
                ST_KEY1: begin
                    unlock_state <= ST_KEY1;
                end
                ST_KEY2: begin
                    unlock_state <= ST_KEY2;
                end
                default: begin
                    unlock_state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================
    // Pointer and latch
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            table_byte_pointer <= {`FTA_PTR_W{1'b0}};
            table_data_latch <= 8'h00;
        end else if (i_soft_rst) begin
            table_byte_pointer <= {`FTA_PTR_W{1'b0}};
            table_data_latch <= 8'h00;
        end else if (tbl_rd || tbl_wr) begin
            // Table access wins over a register write in the same cycle
            table_byte_pointer <= {ptr_space, next_ptr_low};
            if (tbl_rd) begin
                table_data_latch <= i_fl_rd_data;
            end
        end else if (i_sfr_wr && !timer_busy) begin
            if (sfr_hit(i_sfr_addr, `FTA_SFR_LATCH)) begin
                table_data_latch <= i_sfr_wdata;
            end
            if (sfr_hit(i_sfr_addr, `FTA_SFR_PTRL)) begin
                table_byte_pointer[7:0] <= i_sfr_wdata;
            end
            if (sfr_hit(i_sfr_addr, `FTA_SFR_PTRH)) begin
                table_byte_pointer[15:8] <= i_sfr_wdata;
            end
            if (sfr_hit(i_sfr_addr, `FTA_SFR_PTRU)) begin
                table_byte_pointer[21:16] <= i_sfr_wdata[5:0];
            end
        end
    end

    // ==================================================
    // Holding registers
    fta_hold_bank u_hold (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_wr(tbl_wr),
        .i_idx(access_addr[`FTA_WBLK_BITS-1:0]),
        .i_data(table_data_latch),
        .i_clear(timer_done || i_soft_rst),
        .i_rd_idx(i_fl_hold_idx),
        .o_rd_data(o_fl_hold_data)
    );

    // ==================================================
    // Long write timer
    fta_prog_timer #(
        .P_CYCLES(P_LONG_WRITE_CYC)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_start(start_ok),
        .i_abort(abort_op),
        .o_busy(timer_busy),
        .o_done(timer_done)
    );

    // Core held while the timer runs
    assign o_cpu_stall = timer_busy;

    // ==================================================
    // Control register one
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            program_memory_select <= 1'b0;
            config_space_select <= 1'b0;
            erase_select <= 1'b0;
            write_error_flag <= 1'b0;
            write_enable_bit <= 1'b0;
            write_start <= 1'b0;
            erase_op <= 1'b0;
        end else begin
            if (sfr_wr_ctl && !timer_busy) begin
                // Select bits follow software; start bit is set-only
                program_memory_select <= i_sfr_wdata[`FTA_CTL_PGD];
                config_space_select <= i_sfr_wdata[`FTA_CTL_CFG];
                erase_select <= i_sfr_wdata[`FTA_CTL_FREE];
                write_enable_bit <= i_sfr_wdata[`FTA_CTL_WEN];
                write_error_flag <= i_sfr_wdata[`FTA_CTL_ERR];
            end
            if (start_ok) begin
                write_start <= 1'b1;
                erase_op <= i_sfr_wdata[`FTA_CTL_FREE];
            end else if (timer_done || abort_op) begin
                write_start <= 1'b0;
            end
            // Error set wins over a same-cycle software clear
            if (abort_op || start_bad) begin
                write_error_flag <= 1'b1;
            end
            if (i_soft_rst) begin
                // Program and config select bits stay so software can trace the fault
                write_enable_bit <= 1'b0;
                erase_select <= 1'b0;
            end
        end
    end

    // ==================================================
    // Flash array commands
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fl_erase <= 1'b0;
            o_fl_prog <= 1'b0;
            o_fl_op_addr <= {`FTA_PTR_W{1'b0}};
        end else if (start_ok) begin
            if (i_sfr_wdata[`FTA_CTL_FREE]) begin
                // Single 64-byte block only, never bulk
                o_fl_erase <= 1'b1;
                o_fl_op_addr <= {table_byte_pointer[21:6], {`FTA_EBLK_BITS{1'b0}}};
            end else begin
                o_fl_prog <= 1'b1;
                o_fl_op_addr <= {table_byte_pointer[21:5], {`FTA_WBLK_BITS{1'b0}}};
            end
        end else if (timer_done || abort_op) begin
            o_fl_erase <= 1'b0;
            o_fl_prog <= 1'b0;
        end
    end

    // ==================================================
    // Done flag
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_memory_done_irq_flag <= 1'b0;
        end else if (timer_done) begin
            o_memory_done_irq_flag <= 1'b1;
        end else if (i_sfr_wr && sfr_hit(i_sfr_addr, `FTA_SFR_IRQF) && !i_sfr_wdata[0]) begin
            o_memory_done_irq_flag <= 1'b0;
        end
    end

    // ==================================================
    // Register read port, one cycle after the address
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sfr_rdata <= 8'h00;
        end else begin
            case (i_sfr_addr)
                `FTA_SFR_LATCH: begin
                    o_sfr_rdata <= table_data_latch;
                end
                `FTA_SFR_PTRL: begin
                    o_sfr_rdata <= table_byte_pointer[7:0];
                end
                `FTA_SFR_PTRH: begin
                    o_sfr_rdata <= table_byte_pointer[15:8];
                end
                `FTA_SFR_PTRU: begin
                    o_sfr_rdata <= {2'h0, table_byte_pointer[21:16]};
                end
                `FTA_SFR_CTL1: begin
                    o_sfr_rdata <= {program_memory_select, config_space_select, 1'b0, erase_select,
                        write_error_flag, write_enable_bit, write_start, 1'b0};
                end
                `FTA_SFR_IRQF: begin
                    o_sfr_rdata <= {7'h00, o_memory_done_irq_flag};
                end
                default: begin
                    // Guard register is write-only
                    o_sfr_rdata <= 8'h00;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: verification/fta_table_access_sva.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fta_consts.vh"

module fta_table_access_sva #(
    parameter [`FTA_TMR_W-1:0] P_LONG_WRITE_CYC = `FTA_LONG_WRITE_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_soft_rst,
    input wire logic i_sfr_wr,
    input wire logic [`FTA_SFR_AW-1:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_tbl_op,
    input wire logic [1:0] i_tbl_mode,
    input wire logic [`FTA_PTR_W-1:0] o_fl_rd_addr,
    input wire logic o_fl_erase,
    input wire logic o_fl_prog,
    input wire logic [`FTA_PTR_W-1:0] o_fl_op_addr,
    input wire logic o_cpu_stall,
    input wire logic o_memory_done_irq_flag
);
    logic [`FTA_TMR_W-1:0] stall_cnt;
    wire clr_done = i_sfr_wr && i_sfr_addr == `FTA_SFR_IRQF && !i_sfr_wdata[0];
    wire start_wr = i_sfr_wr && i_sfr_addr == `FTA_SFR_CTL1 && i_sfr_wdata[`FTA_CTL_WR] && i_sfr_wdata[`FTA_CTL_WEN];

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    // ==================================================
    // Stall length counter
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stall_cnt <= 15'h0;
        end else if (o_cpu_stall) begin
            stall_cnt <= stall_cnt + 15'h1;
        end else begin
            stall_cnt <= 15'h0;
        end
    end

    // ==================================================
    // Properties
    property p_stall_len;
        $fell(o_cpu_stall) && !$past(i_soft_rst) |-> stall_cnt == P_LONG_WRITE_CYC;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    property p_done_set;
        $fell(o_cpu_stall) && !$past(i_soft_rst) |-> o_memory_done_irq_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");
    property p_done_sticky;
        o_memory_done_irq_flag && !clr_done && !i_soft_rst |=> o_memory_done_irq_flag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped");
    property p_op_stall;
        o_fl_erase || o_fl_prog |-> o_cpu_stall;
    endproperty
    a_op_stall: assert property (p_op_stall) else $error("cycle without stall");
    property p_erase_addr;
        o_fl_erase |-> o_fl_op_addr[5:0] == 6'h0 && !o_fl_prog;
    endproperty
    a_erase_addr: assert property (p_erase_addr) else $error("erase address low bits");
    property p_prog_addr;
        o_fl_prog |-> o_fl_op_addr[4:0] == 5'h0;
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("program address low bits");
    property p_start_cause;
        $rose(o_cpu_stall) |-> $past(start_wr);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("cycle without start write");
    property p_postinc;
        (i_tbl_op && !o_cpu_stall && !i_sfr_wr && !i_soft_rst && i_tbl_mode == `FTA_MODE_POSTINC)
            ##1 (i_tbl_mode == `FTA_MODE_KEEP)
            |-> o_fl_rd_addr[21] == $past(o_fl_rd_addr[21]) && o_fl_rd_addr[20:0] == $past(o_fl_rd_addr[20:0]) + 21'h1;
    endproperty
    a_postinc: assert property (p_postinc) else $error("post increment wrong");
    property p_stall_blocks;
        (o_cpu_stall && i_tbl_op && !i_soft_rst && i_tbl_mode == `FTA_MODE_POSTINC)
            ##1 (i_tbl_mode == `FTA_MODE_KEEP) |-> $stable(o_fl_rd_addr);
    endproperty
    a_stall_blocks: assert property (p_stall_blocks) else $error("table op during stall");
    property p_end_clear;
        $fell(o_cpu_stall) |-> !o_fl_erase && !o_fl_prog;
    endproperty
    a_end_clear: assert property (p_end_clear) else $error("cycle outlives stall");
endmodule
`default_nettype wire

/* File: verification/fta_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fta_consts.vh"

module fta_flash_model (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic [`FTA_PTR_W-1:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    input wire logic i_prog,
    output logic [`FTA_WBLK_BITS-1:0] o_hold_idx,
    input wire logic [7:0] i_hold_data
);
    logic [7:0] cap [0:`FTA_WBLK_BYTES-1];
    logic [`FTA_WBLK_BITS-1:0] idx_d;
    logic cap_en;

    // Byte depends on word half and on space bit
    assign o_rd_data = i_rd_addr[7:0] ^ {i_rd_addr[21], i_rd_addr[14:8]};

    // ==================================================
    // Holding block capture, hold data lags index by one
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hold_idx <= 5'h0;
            idx_d <= 5'h0;
            cap_en <= 1'b0;
        end else begin
            o_hold_idx <= i_prog ? o_hold_idx + 5'h1 : 5'h0;
            idx_d <= o_hold_idx;
            cap_en <= i_prog;
            if (cap_en) begin
                cap[idx_d] <= i_hold_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/test_fta_table_access.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fta_consts.vh"

module test_fta_table_access;
    localparam [`FTA_TMR_W-1:0] P_CYC = 15'h14;
    logic mclk, arst_n, soft_rst, sfr_wr, tbl_op, tbl_is_write, fl_erase, fl_prog, cpu_stall, done_flag;
    logic [2:0] sfr_addr;
    logic [1:0] tbl_mode, m;
    logic [7:0] sfr_wdata, sfr_rdata, fl_rd_data, hold_data, rv;
    logic [21:0] fl_rd_addr, fl_op_addr, p, q;
    logic [4:0] hold_idx;
    logic [1:0] mv [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int miscompares = 0;
    int num_checks = 0;
    int n, k;

    fta_table_access #(.P_LONG_WRITE_CYC(P_CYC)) fta_table_access_i (
        .i_mclk(mclk), .i_arst_n(arst_n), .i_soft_rst(soft_rst), .i_sfr_wr(sfr_wr), .i_sfr_addr(sfr_addr),
        .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_tbl_op(tbl_op), .i_tbl_is_write(tbl_is_write),
        .i_tbl_mode(tbl_mode), .o_fl_rd_addr(fl_rd_addr), .i_fl_rd_data(fl_rd_data), .o_fl_erase(fl_erase),
        .o_fl_prog(fl_prog), .o_fl_op_addr(fl_op_addr), .i_fl_hold_idx(hold_idx), .o_fl_hold_data(hold_data),
        .o_cpu_stall(cpu_stall), .o_memory_done_irq_flag(done_flag));
    fta_flash_model fta_flash_model_i (
        .i_mclk(mclk), .i_arst_n(arst_n), .i_rd_addr(fl_rd_addr), .o_rd_data(fl_rd_data), .i_prog(fl_prog),
        .o_hold_idx(hold_idx), .i_hold_data(hold_data));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ==================================================
    // Compare and report
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk22(input logic [21:0] got, input logic [21:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t address %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==================================================
    // Core side accesses
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge mclk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        @(posedge mclk);
        #1;
        v = sfr_rdata;
    endtask
    task automatic top(input logic w, input logic [1:0] md);
        @(posedge mclk);
        tbl_op <= 1'b1;
        tbl_is_write <= w;
        tbl_mode <= md;
        @(posedge mclk);
        tbl_op <= 1'b0;
        tbl_mode <= `FTA_MODE_KEEP;
        #1;
    endtask
    task automatic unlock(input logic [7:0] c);
        wr(`FTA_SFR_GUARD, `FTA_KEY_FIRST);
        wr(`FTA_SFR_GUARD, `FTA_KEY_SECOND);
        wr(`FTA_SFR_CTL1, c);
    endtask
    task automatic wait_idle(output int c);
        c = 0;
        while (cpu_stall !== 1'b0) begin
            if (c == 1000) begin
                miscompares++;
                conclude();
            end
            @(posedge mclk);
            #1;
            c++;
        end
    endtask
    function automatic logic [21:0] step(input logic [21:0] a, input logic [20:0] d);
        return {a[21], a[20:0] + d};
    endfunction

    // ==================================================
    // Scenarios
    initial begin
        arst_n = 1'b0;
        soft_rst = 1'b0;
        sfr_wr = 1'b0;
        sfr_addr = 3'h0;
        sfr_wdata = 8'h00;
        tbl_op = 1'b0;
        tbl_is_write = 1'b0;
        tbl_mode = 2'h0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            rd(k[2:0], rv);
            chk8(rv, 8'h00);
        end
        wr(`FTA_SFR_PTRL, 8'h34);
        wr(`FTA_SFR_PTRH, 8'h12);
        wr(`FTA_SFR_PTRU, 8'hff);
        rd(`FTA_SFR_PTRU, rv);
        chk8(rv, 8'h3f);
        chk22(fl_rd_addr, 22'h3f1234);
        // Pointer at the top of the space wraps the low field only
        wr(`FTA_SFR_PTRL, 8'hff);
        wr(`FTA_SFR_PTRH, 8'hff);
        p = 22'h3fffff;
        for (k = 0; k < 4; k++) begin
            m = mv[k];
            q = (m == `FTA_MODE_PREINC) ? step(p, 21'h1) : p;
            p = (m == `FTA_MODE_POSTINC) ? step(p, 21'h1) : (m == `FTA_MODE_POSTDEC) ? step(p, 21'h1fffff) : q;
            top(1'b0, m);
            chk22(fl_rd_addr, p);
            rd(`FTA_SFR_LATCH, rv);
            chk8(rv, q[7:0] ^ {q[21], q[14:8]});
        end
        wr(`FTA_SFR_PTRU, 8'h0a);
        wr(`FTA_SFR_PTRH, 8'hbc);
        wr(`FTA_SFR_PTRL, 8'he0);
        for (k = 0; k < 3; k++) begin
            wr(`FTA_SFR_LATCH, 8'hc0 + k[7:0]);
            top(1'b1, `FTA_MODE_POSTINC);
        end
        wr(`FTA_SFR_CTL1, 8'h84);
        unlock(8'h86);
        chk8({5'h0, cpu_stall, fl_prog, fl_erase}, 8'h06);
        chk22(fl_op_addr, 22'h0abce0);
        wait_idle(n);
        chk8(n[7:0], P_CYC[7:0]);
        for (k = 0; k < 4; k++) begin
            chk8(fta_flash_model_i.cap[k], k < 3 ? 8'hc0 + k[7:0] : `FTA_HOLD_RESET);
        end
        rd(`FTA_SFR_CTL1, rv);
        chk8(rv & 8'h02, 8'h00);
        rd(`FTA_SFR_IRQF, rv);
        chk8(rv, 8'h01);
        wr(`FTA_SFR_IRQF, 8'h00);
        rd(`FTA_SFR_IRQF, rv);
        chk8(rv, 8'h00);
        // Erase with nonzero offset bits, table op refused meanwhile
        wr(`FTA_SFR_PTRL, 8'h7f);
        wr(`FTA_SFR_PTRH, 8'h23);
        wr(`FTA_SFR_PTRU, 8'h01);
        wr(`FTA_SFR_CTL1, 8'h94);
        unlock(8'h96);
        chk8({5'h0, cpu_stall, fl_prog, fl_erase}, 8'h05);
        chk22(fl_op_addr, 22'h012340);
        top(1'b0, `FTA_MODE_POSTINC);
        wait_idle(n);
        chk22(fl_rd_addr, 22'h01237f);
        rd(`FTA_SFR_IRQF, rv);
        chk8(rv, 8'h01);
        // Broken sequence, config space, enable not set beforehand
        for (k = 0; k < 3; k++) begin
            wr(`FTA_SFR_CTL1, 8'h00);
            wr(`FTA_SFR_CTL1, k == 2 ? 8'h00 : 8'h84);
            wr(`FTA_SFR_GUARD, `FTA_KEY_FIRST);
            if (k == 0) wr(`FTA_SFR_PTRL, 8'h00);
            wr(`FTA_SFR_GUARD, `FTA_KEY_SECOND);
            wr(`FTA_SFR_CTL1, k == 1 ? 8'hc6 : 8'h86);
            chk8({7'h0, cpu_stall}, 8'h00);
            rd(`FTA_SFR_CTL1, rv);
            chk8(rv & 8'h08, 8'h08);
        end
        // Abort in mid-cycle keeps the program memory select bit
        wr(`FTA_SFR_CTL1, 8'h94);
        unlock(8'h96);
        repeat (5) @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
        #1;
        chk8({6'h0, cpu_stall, fl_erase}, 8'h00);
        rd(`FTA_SFR_CTL1, rv);
        chk8(rv & 8'h88, 8'h88);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`FTA_SFR_CTL1, rv);
        chk8(rv, `FTA_CTL_RESET);
        conclude();
    end
endmodule

bind fta_table_access fta_table_access_sva #(.P_LONG_WRITE_CYC(P_LONG_WRITE_CYC)) sva_i (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_soft_rst(i_soft_rst), .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_tbl_op(i_tbl_op), .i_tbl_mode(i_tbl_mode), .o_fl_rd_addr(o_fl_rd_addr),
    .o_fl_erase(o_fl_erase), .o_fl_prog(o_fl_prog), .o_fl_op_addr(o_fl_op_addr), .o_cpu_stall(o_cpu_stall),
    .o_memory_done_irq_flag(o_memory_done_irq_flag));
`default_nettype wire
